// >>> rtl/urx_receiver.sv
// Serial receiver with start-of-frame wake-up, auto-baud sync check
// and an AXI4-Lite register slave.
// Assumes rxd_i and standby_i come from pins or the power controller;
// rxd_i is synchronised here, standby_i is on the system clock.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module urx_receiver (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic rxd_i,
  input wire logic standby_i,
  output logic wake_o,
  output logic irq_o
);
  // ==========================================================
  // Helpers
  // Word match on an aligned address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction : hit
  // Value lies within one eighth of the reference
  function automatic logic near(input logic [17:0] val, input logic [17:0] ref_v);
    logic [17:0] diff;
    diff = (val > ref_v) ? val - ref_v : ref_v - val;
    return diff <= (ref_v >> urx_pkg::TOL_SHIFT);
  endfunction : near
  // ==========================================================
  // Declarations
  urx_pkg::urx_ctrl_t ctrl;
  urx_pkg::urx_irq_t irq_status, irq_mask, irq_events;
  urx_pkg::urx_state_t state, next_state;
  logic [15:0] baud, cnt, next_cnt;
  logic [7:0] receive_buffer, shift, next_shift;
  logic [2:0] idx, next_idx;
  logic [1:0] edges, next_edges;
  logic [17:0] iv, next_iv, iv0, next_iv0;
  logic [19:0] span, next_span;
  logic receive_complete_flag, receive_start_flag, bad_sync_flag, ferr_flag;
  logic halted, sfd_armed, expect_sync, wake_req;
  logic rx_meta, rx_sync, rx_prev;
  logic done_ev, ferr_ev, break_ev, bad_ev, sync_ok_ev;
  logic aw_held, w_held, bvalid, rvalid;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rdata, rd_value;
  logic [3:0] w_strb;
  logic [1:0] bresp, rresp;
  // ==========================================================
  // AXI4-Lite write channel
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_i;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  wire wr_fire = (aw_held | aw_take) & (w_held | w_take) & ~bvalid;
  wire wr_ctrl = wr_fire & hit(wr_addr, urx_pkg::OFS_CONTROL_SECOND) & wr_strb[0];
  wire wr_status = wr_fire & hit(wr_addr, urx_pkg::OFS_STATUS) & wr_strb[0];
  wire wr_baud = wr_fire & hit(wr_addr, urx_pkg::OFS_BAUD);
  wire wr_mask = wr_fire & hit(wr_addr, urx_pkg::OFS_IRQ_MASK) & wr_strb[0];
  wire wr_mapped = hit(wr_addr, urx_pkg::OFS_CONTROL_SECOND) | hit(wr_addr, urx_pkg::OFS_STATUS)
                 | hit(wr_addr, urx_pkg::OFS_RECEIVE_BUFFER) | hit(wr_addr, urx_pkg::OFS_BAUD)
                 | hit(wr_addr, urx_pkg::OFS_IRQ_STATUS) | hit(wr_addr, urx_pkg::OFS_IRQ_MASK);
  assign s_axi_awready_o = ~aw_held & ~bvalid;
  assign s_axi_wready_o = ~w_held & ~bvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  // Hold address and data until both have arrived
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      aw_held <= ~wr_fire & (aw_held | aw_take);
      w_held <= ~wr_fire & (w_held | w_take);
      if (aw_take) aw_addr <= s_axi_awaddr_i;
      if (w_take) w_data <= s_axi_wdata_i;
      if (w_take) w_strb <= s_axi_wstrb_i;
    end
  end
  // Write response
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid <= 1'b0;
      bresp <= urx_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? urx_pkg::RESP_OKAY : urx_pkg::RESP_DECERR;
    end else if (s_axi_bready_i) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  wire rd_fire = s_axi_arvalid_i & s_axi_arready_o;
  wire rd_ctrl = hit(s_axi_araddr_i, urx_pkg::OFS_CONTROL_SECOND);
  wire rd_status = hit(s_axi_araddr_i, urx_pkg::OFS_STATUS);
  wire rd_buf = hit(s_axi_araddr_i, urx_pkg::OFS_RECEIVE_BUFFER);
  wire rd_baud = hit(s_axi_araddr_i, urx_pkg::OFS_BAUD);
  wire rd_irq = hit(s_axi_araddr_i, urx_pkg::OFS_IRQ_STATUS);
  wire rd_mask = hit(s_axi_araddr_i, urx_pkg::OFS_IRQ_MASK);
  wire rd_mapped = rd_ctrl | rd_status | rd_buf | rd_baud | rd_irq | rd_mask;
  wire buf_read = rd_fire & rd_buf;
  wire irq_read = rd_fire & rd_irq;
  wire rx_busy = state != urx_pkg::RX_IDLE;
  // Status view; start flag hidden outside standby
  wire [5:0] status_view = {halted, rx_busy, ferr_flag, bad_sync_flag,
                            receive_start_flag & standby_i, receive_complete_flag};
  // Read data selection
  assign rd_value = rd_ctrl ? {28'h000_0000, ctrl}
                  : rd_status ? {26'h000_0000, status_view}
                  : rd_buf ? {24'h00_0000, receive_buffer}
                  : rd_baud ? {16'h0000, baud}
                  : rd_irq ? {28'h000_0000, irq_status}
                  : rd_mask ? {28'h000_0000, irq_mask}
                  : 32'h0000_0000;
  assign s_axi_arready_o = ~rvalid;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  // Read data and response
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= urx_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= rd_mapped ? urx_pkg::RESP_OKAY : urx_pkg::RESP_DECERR;
    end else if (s_axi_rready_i) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control, baud and mask registers
  wire autobaud = (ctrl.receive_mode_field == urx_pkg::GENERIC_AUTOBAUD_MODE)
                | (ctrl.receive_mode_field == urx_pkg::CONSTRAINED_AUTOBAUD_MODE);
  wire sfd_reenable = wr_ctrl & wr_data[urx_pkg::CTRL_SFD_BIT] & ~ctrl.frame_detect_enable;
  wire [19:0] span_p1 = span + 20'h00001;
  wire [15:0] new_period = span_p1[18:urx_pkg::SYNC_SHIFT];
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= urx_pkg::CTRL_RESET;
      irq_mask <= urx_pkg::IRQ_MASK_RESET;
      baud <= urx_pkg::BAUD_RESET;
    end else begin
      if (wr_ctrl) ctrl <= wr_data[3:0];
      if (wr_mask) irq_mask <= wr_data[3:0];
      if (sync_ok_ev) baud <= new_period;
      else if (wr_baud) baud <= {wr_strb[1] ? wr_data[15:8] : baud[15:8],
                                 wr_strb[0] ? wr_data[7:0] : baud[7:0]};
    end
  end
  // ==========================================================
  // Line synchroniser and edge detection
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= rxd_i;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  wire rx_fall = rx_prev & ~rx_sync;
  wire rx_active = ctrl.receiver_enable_bit & ~halted;
  wire tick = cnt == 16'h0000;
  wire [15:0] half_bit = {1'b0, baud[15:1]};
  wire sfd_restart = sfd_armed & rx_fall & rx_active;
  wire idle_start = (state == urx_pkg::RX_IDLE) & rx_fall & rx_active
                  & (~standby_i | ctrl.frame_detect_enable);
  wire standby_start = idle_start & standby_i;
  // ==========================================================
  // Receiver and sync-field sequencing
  always_comb begin
    next_state = state;
    next_cnt = tick ? cnt : cnt - 16'h0001;
    next_idx = idx;
    next_shift = shift;
    next_edges = edges;
    next_span = span;
    next_iv = iv;
    next_iv0 = iv0;
    done_ev = 1'b0;
    ferr_ev = 1'b0;
    break_ev = 1'b0;
    bad_ev = 1'b0;
    sync_ok_ev = 1'b0;
    if (!rx_active) begin
      next_state = urx_pkg::RX_IDLE;
    end else if (sfd_restart) begin
      next_state = urx_pkg::RX_START;
      next_cnt = half_bit;
    end else begin
      unique case (state)
        urx_pkg::RX_IDLE: begin
          if (idle_start) begin
            next_state = (expect_sync & autobaud) ? urx_pkg::RX_SYNC : urx_pkg::RX_START;
            next_cnt = half_bit;
            next_edges = 2'h0;
            next_span = 20'h00000;
            next_iv = 18'h00000;
          end
        end
        urx_pkg::RX_START: begin
          if (tick) begin
            next_state = rx_sync ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
            next_cnt = baud - 16'h0001;
            next_idx = 3'h0;
          end
        end
        urx_pkg::RX_DATA: begin
          if (tick) begin
            next_shift = {rx_sync, shift[7:1]};
            next_cnt = baud - 16'h0001;
            next_idx = idx + 3'h1;
            if (idx == urx_pkg::DATA_LAST_BIT) next_state = urx_pkg::RX_STOP;
          end
        end
        urx_pkg::RX_STOP: begin
          if (tick) begin
            next_state = urx_pkg::RX_IDLE;
            done_ev = rx_sync;
            break_ev = ~rx_sync & (shift == 8'h00);
            ferr_ev = ~rx_sync & (shift != 8'h00);
          end
        end
        urx_pkg::RX_SYNC: begin
          next_span = span_p1;
          next_iv = iv + 18'h00001;
          if (rx_fall) begin
            next_iv = 18'h00000;
            next_edges = edges + 2'h1;
            if (edges == 2'h0) next_iv0 = iv;
            else if (!near(iv, iv0)) bad_ev = 1'b1;
            if (!bad_ev && edges == urx_pkg::SYNC_LAST_INTERVAL) begin
              if (span_p1[19] || new_period == 16'h0000) bad_ev = 1'b1;
              else if (ctrl.receive_mode_field == urx_pkg::CONSTRAINED_AUTOBAUD_MODE
                       && !near({2'b00, new_period}, {2'b00, baud})) bad_ev = 1'b1;
              else sync_ok_ev = 1'b1;
              next_state = urx_pkg::RX_IDLE;
            end
          end else if (iv == urx_pkg::INTERVAL_MAX) begin
            bad_ev = 1'b1;
          end
          if (bad_ev) next_state = urx_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receiver state registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= urx_pkg::RX_IDLE;
      cnt <= 16'h0000;
      idx <= 3'h0;
      shift <= 8'h00;
      edges <= 2'h0;
      span <= 20'h00000;
      iv <= 18'h00000;
      iv0 <= 18'h00000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      shift <= next_shift;
      edges <= next_edges;
      span <= next_span;
      iv <= next_iv;
      iv0 <= next_iv0;
    end
  end
  // Received byte
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) receive_buffer <= 8'h00;
    else if (done_ev) receive_buffer <= shift;
  end
  // ==========================================================
  // Detector arming, sync expectation and stall
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sfd_armed <= 1'b0;
      expect_sync <= 1'b0;
      halted <= 1'b0;
    end else begin
      if (!ctrl.frame_detect_enable || !rx_active || sfd_restart) sfd_armed <= sfd_reenable & rx_busy;
      else if ((buf_read & rx_busy & ~standby_i) | (sfd_reenable & rx_busy)) sfd_armed <= 1'b1;
      if (!autobaud || state == urx_pkg::RX_SYNC) expect_sync <= 1'b0;
      else if (break_ev) expect_sync <= 1'b1;
      if (bad_ev) halted <= 1'b1;
      else if (!ctrl.receiver_enable_bit) halted <= 1'b0;
    end
  end

  // ==========================================================
  // Status flags, set wins over clear
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      receive_complete_flag <= 1'b0;
      receive_start_flag <= 1'b0;
      bad_sync_flag <= 1'b0;
      ferr_flag <= 1'b0;
    end else begin
      receive_complete_flag <= done_ev | (receive_complete_flag & ~buf_read);
      receive_start_flag <= standby_start
                          | (receive_start_flag & ~(wr_status & wr_data[urx_pkg::ST_RXS_BIT]));
      bad_sync_flag <= bad_ev | (bad_sync_flag & ~(wr_status & wr_data[urx_pkg::ST_BAD_SYNC_BIT]));
      ferr_flag <= ferr_ev | (ferr_flag & ~(wr_status & wr_data[urx_pkg::ST_FERR_BIT]));
    end
  end

  // ==========================================================
  // Wake request and interrupt
  // Start event reaches the interrupt only in standby
  assign irq_events = {ferr_ev, bad_ev, standby_start, done_ev};
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status <= 4'h0;
      wake_req <= 1'b0;
    end else begin
      irq_status <= irq_events | (irq_read ? 4'h0 : irq_status);
      wake_req <= standby_start | (wake_req & standby_i);
    end
  end

  assign wake_o = wake_req;
  assign irq_o = |(irq_status & irq_mask);
endmodule : urx_receiver

// >>> rtl/urx_pkg.sv
// Constants, register map and carrier types of the serial receiver
// with start-of-frame wake-up and auto-baud synchronisation checking.
// Assumes an AXI4-Lite register bus with 32-bit data and byte addresses.
package urx_pkg;

  // ==========================================================
  // Register map (byte offsets)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL_SECOND = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RECEIVE_BUFFER = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SFD_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int ST_RXS_BIT = 1;
  localparam int ST_BAD_SYNC_BIT = 2;
  localparam int ST_FERR_BIT = 3;

  // ==========================================================
  // Receive mode encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] GENERIC_AUTOBAUD_MODE = 2'h1;
  localparam logic [1:0] CONSTRAINED_AUTOBAUD_MODE = 2'h2;

  // ==========================================================
  // Reset values and counts
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] BAUD_RESET = 16'h043d;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [2:0] DATA_LAST_BIT = 3'h7;
  localparam logic [1:0] SYNC_LAST_INTERVAL = 2'h3;
  localparam int SYNC_SHIFT = 3;
  localparam int TOL_SHIFT = 3;
  localparam logic [17:0] INTERVAL_MAX = 18'h3ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [1:0] receive_mode_field;
    logic frame_detect_enable;
    logic receiver_enable_bit;
  } urx_ctrl_t;

  typedef struct packed {
    logic frame_error;
    logic bad_sync;
    logic rx_start;
    logic rx_complete;
  } urx_irq_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP,
    RX_SYNC
  } urx_state_t;

endpackage : urx_pkg

// >>> verification/urx_receiver_sva.sv
// Checker of bus handshakes, the wake output and the start flag.
// Assumes a bind onto urx_receiver; it sees only that module's ports.
`timescale 1ns/1ps
module urx_receiver_sva (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic standby_i,
  input wire logic wake_o
);
  // ======
  // Transfer decode; word index 1 is the status register
  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire wr_take = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  wire st_rd = ar_take && s_axi_araddr_i[7:2] == 6'h01;
  wire bad_rd = ar_take && s_axi_araddr_i[7:2] > 6'h05;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // ======
  // Bus answers, holding and refusal
  a_write_answer: assert property (wr_take |=> s_axi_bvalid_o)
    else $error("write answer late");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  a_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  a_unmapped_read: assert property (bad_rd |=> s_axi_rresp_o == urx_pkg::RESP_DECERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  // ======
  // Start flag and wake output
  a_start_flag_zero: assert property (st_rd && !standby_i |=> s_axi_rdata_o[1] == 1'h0)
    else $error("start flag seen in active mode");
  a_wake_drops: assert property (!standby_i |=> !wake_o)
    else $error("wake high outside standby");
  a_wake_holds: assert property (wake_o && standby_i |=> wake_o)
    else $error("wake released in standby");
  c_wake: cover property ($rose(wake_o));
  c_unmapped: cover property (bad_rd);
  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule : urx_receiver_sva

// >>> verification/urx_tx_model.sv
// Remote transmitter model driving the receive line.
// Assumes send_frame is called just after a rising clock edge.
`timescale 1ns/1ps
module urx_tx_model (
  input wire logic clk_sys_i,
  output logic line_o
);
  // ======
  // Line idles high outside frames
  initial line_o = 1'h1;
  // Start bit of first clocks, 8 bits LSB first, stop, idle gap
  task automatic send_frame(input logic [7:0] d, input int clks, input int first, input logic stop);
    line_o <= 1'h0;
    repeat (first) @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= d[i];
      repeat (clks) @(posedge clk_sys_i);
    end
    line_o <= stop;
    repeat (clks) @(posedge clk_sys_i);
    line_o <= 1'h1;
    repeat (2 * clks) @(posedge clk_sys_i); // Quiet gap before any re-arming
  endtask : send_frame
endmodule : urx_tx_model

// >>> verification/urx_receiver_tb.sv
// Self-checking bench: register master, line model, queue model.
// Assumes urx_pkg, urx_receiver, urx_tx_model and urx_receiver_sva.
`timescale 1ns/1ps
module urx_receiver_tb;
  logic clk_sys_i = 1'h0;
  logic reset_i = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, b;
  logic [31:0] wdata = 32'h0, rdata, rd_data;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, standby = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, rxd, wake, irq;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checked = 0;
  int seed = 91;
  int baud = 16;
  // ======
  // Clock of 8 ns, design and line model
  always #4 clk_sys_i = ~clk_sys_i;
  urx_receiver i_urx_receiver (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rxd_i(rxd),
    .standby_i(standby), .wake_o(wake), .irq_o(irq)
  );
  urx_tx_model tx (.clk_sys_i(clk_sys_i), .line_o(rxd));
  // ======
  // Register bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    // Each channel held until its own ready is sampled high
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_i);
      if (!aw_done && awready) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_done && wready) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    // Random pause before ready, then held until the answer
    repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys_i);
    bready <= 1'h1;
    @(posedge clk_sys_i);
    while (!bvalid) @(posedge clk_sys_i);
    wr_resp = bresp;
    bready <= 1'h0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    @(posedge clk_sys_i);
    while (!arready) @(posedge clk_sys_i);
    arvalid <= 1'h0;
    repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys_i);
    rready <= 1'h1;
    @(posedge clk_sys_i);
    while (!rvalid) @(posedge clk_sys_i);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'h0;
  endtask : axi_read
  // ======
  // Comparisons against expected values and the queue model
  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] got);
    checked++;
    if (got !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask : chk_val
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    axi_read(a);
    chk_val($sformatf("register %h", a), e, rd_data);
    chk_val($sformatf("response %h", a), {30'h0, a > 8'h17 ? urx_pkg::RESP_DECERR : urx_pkg::RESP_OKAY}, {30'h0, rd_resp});
  endtask : chk_reg
  task automatic chk_pin(input string what, input logic e, input logic got);
    @(posedge clk_sys_i);
    chk_val(what, {31'h0, e}, {31'h0, got});
  endtask : chk_pin
  task automatic chk_rx;
    axi_read(urx_pkg::OFS_RECEIVE_BUFFER);
    chk_val("receive_buffer", {24'h0, exp_q.pop_front()}, rd_data);
  endtask : chk_rx
  // Send one frame at the current rate, queued if it must arrive
  task automatic send(input logic [7:0] d, input logic keep);
    if (keep) exp_q.push_back(d);
    tx.send_frame(d, baud, baud, 1'h1);
  endtask : send
  task automatic wait_idle;
    axi_read(urx_pkg::OFS_STATUS);
    while (rd_data[4] !== 1'h0) axi_read(urx_pkg::OFS_STATUS);
  endtask : wait_idle
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // ======
  // Watchdog: runs need about 5k cycles, limit is 40k
  initial begin
    #320000;
    miscompares++;
    report_and_stop();
  end
  // ======
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'h0;
    @(posedge clk_sys_i);
    chk_reg(urx_pkg::OFS_CONTROL_SECOND, 32'h0);
    chk_reg(urx_pkg::OFS_BAUD, 32'h43d);
    chk_reg(urx_pkg::OFS_IRQ_MASK, 32'h0);
    chk_reg(8'h18, 32'h0);
    axi_write(8'h18, 32'hf);
    chk_val("write response", 32'h3, {30'h0, wr_resp});
    $display("test reset done");
    // Active frame with detector on, interrupt masked then unmasked
    axi_write(urx_pkg::OFS_BAUD, 32'h10);
    axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'h3);
    send(8'($random(seed)), 1'h1);
    chk_pin("irq_o", 1'h0, irq);
    chk_reg(urx_pkg::OFS_STATUS, 32'h1);
    axi_write(urx_pkg::OFS_IRQ_MASK, 32'hf);
    chk_pin("irq_o", 1'h1, irq);
    chk_reg(urx_pkg::OFS_IRQ_STATUS, 32'h1);
    chk_pin("irq_o", 1'h0, irq);
    chk_rx();
    $display("test active frame done");
    // Mid-frame arming restarts at the bit 1 falling edge
    for (int t = 0; t < 2; t++) begin
      b = 8'($random(seed)) & 8'hfd | 8'h01;
      axi_write(urx_pkg::OFS_CONTROL_SECOND, t == 1 ? 32'h1 : 32'h3);
      exp_q.push_back({2'h3, b[7:2]});
      fork
        tx.send_frame(b, baud, baud, 1'h1);
        begin
          repeat (8) @(posedge clk_sys_i);
          if (t == 1) axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'h3);
          else axi_read(urx_pkg::OFS_RECEIVE_BUFFER);
        end
      join
      wait_idle();
      chk_rx();
    end
    $display("test restart done");
    // Standby wake-up by an incoming frame
    axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'h1);
    axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'h3);
    standby <= 1'h1;
    send(8'($random(seed)), 1'h1);
    chk_pin("wake_o", 1'h1, wake);
    chk_reg(urx_pkg::OFS_STATUS, 32'h3);
    chk_rx();
    standby <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    chk_pin("wake_o", 1'h0, wake);
    chk_reg(urx_pkg::OFS_IRQ_STATUS, 32'h3);
    $display("test standby done");
    // Good sync retunes the rate; bad sync halts until re-enable
    axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'h5);
    tx.send_frame(8'h00, baud, baud, 1'h0);
    tx.send_frame(8'h55, 24, 24, 1'h1);
    baud = 24;
    chk_reg(urx_pkg::OFS_BAUD, 32'h18);
    chk_reg(urx_pkg::OFS_STATUS, 32'h0);
    for (int m = 1; m < 3; m++) begin
      axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'(m * 4 + 1));
      tx.send_frame(8'h00, baud, baud, 1'h0);
      tx.send_frame(8'h55, baud, 3 * baud, 1'h1);
      chk_pin("irq_o", 1'h1, irq);
      chk_reg(urx_pkg::OFS_STATUS, 32'h24);
      chk_reg(urx_pkg::OFS_IRQ_STATUS, 32'h4);
      send(8'($random(seed)), 1'h0);
      chk_reg(urx_pkg::OFS_STATUS, 32'h24);
      axi_write(urx_pkg::OFS_STATUS, 32'h4);
      send(8'($random(seed)), 1'h0);
      chk_reg(urx_pkg::OFS_STATUS, 32'h20);
      axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'(m * 4));
      axi_write(urx_pkg::OFS_CONTROL_SECOND, 32'(m * 4 + 1));
      send(8'($random(seed)), 1'h1);
      chk_reg(urx_pkg::OFS_STATUS, 32'h1);
      chk_rx();
      chk_reg(urx_pkg::OFS_IRQ_STATUS, 32'h1);
    end
    $display("test sync done");
    report_and_stop();
  end
endmodule : urx_receiver_tb

bind urx_receiver urx_receiver_sva u_sva (
  .clk_sys_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .standby_i, .wake_o
);
